//--- gpd_defines.vh
// register map, field positions and reset values of the port 2 data / port 0 set block
`ifndef GPD_DEFINES_VH
`define GPD_DEFINES_VH

// register byte addresses
`define GPD_P2_ADDR         32'hffff0d40
`define GPD_P0SET_ADDR      32'hffff0d24

// port 2 data register field bases; a pin's bit is base plus its pin number
`define GPD_P2_DIR_BASE     24
`define GPD_P2_OUT_BASE     16
`define GPD_P2_IN_BASE      0
// port 2 pin numbers, in port order 2.0, 2.1, 2.4, 2.5, 2.6
`define GPD_P2_PIN0         0
`define GPD_P2_PIN1         1
`define GPD_P2_PIN2         4
`define GPD_P2_PIN3         5
`define GPD_P2_PIN4         6
// pin 2.4 has a direction bit but no output bit
`define GPD_P2_NO_OUT_IDX   2
// diagnostic paths: pin 2.5 for writes, pin 2.4 for readback
`define GPD_P2_HVWR_IDX     3
`define GPD_P2_HVRD_IDX     2

// port 0 set register: bits 20..16 set pins 0.4..0.0
`define GPD_P0SET_LSB       16
`define GPD_P0SET_MSB       20

// reset values
`define GPD_DIR_RST         5'h00
`define GPD_OUT_RST         5'h00
`define GPD_P0_RST          5'h00
`define GPD_RDATA_RST       32'h00000000

`endif

//--- gpd_sync.v
// two-flop synchroniser for a vector of asynchronous pin levels
`timescale 1ns/1ns
module gpd_sync #(
    parameter WIDTH = 5
) (
    input  wire             clock,   // system clock
    input  wire             arst_n,  // async reset, active low
    input  wire [WIDTH-1:0] asyncIn, // levels from outside the clock domain
    output wire [WIDTH-1:0] syncOut  // levels after two flops
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg stage1_reg;
            reg stage2_reg;
            // stage1 is read by stage2 only
            always @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    stage1_reg <= 1'b0;
                    stage2_reg <= 1'b0;
                end else begin
                    stage1_reg <= asyncIn[i];
                    stage2_reg <= stage1_reg;
                end
            end
            assign syncOut[i] = stage2_reg;
        end
    endgenerate
endmodule // gpd_sync

//--- gpd_apb_decode.v
// apb address decode and phase strobes for the gpio register pair
`timescale 1ns/1ns
`include "gpd_defines.vh"
module gpd_apb_decode (
    input  wire        psel,      // apb select
    input  wire        penable,   // apb access phase
    input  wire        pwrite,    // apb direction
    input  wire [31:0] paddr,     // apb byte address
    output wire        setupRd,   // setup cycle of a read
    output wire        setupErr,  // setup cycle of an unmapped access
    output wire        hitP2,     // address selects port 2 data register
    output wire        wrP2,      // port 2 data write takes effect
    output wire        wrP0Set    // port 0 set write takes effect
);
    wire isP2;
    wire isP0Set;
    wire setup;
    wire access;

    assign isP2     = (paddr == `GPD_P2_ADDR);
    assign isP0Set  = (paddr == `GPD_P0SET_ADDR);
    assign setup    = psel & ~penable;
    // pready is always high in the access phase, so access means completion
    assign access   = psel & penable;
    assign setupRd  = setup & ~pwrite;
    assign setupErr = setup & ~isP2 & ~isP0Set;
    assign hitP2    = isP2;
    assign wrP2     = access & pwrite & isP2;
    assign wrP0Set  = access & pwrite & isP0Set;
endmodule // gpd_apb_decode

//--- gpd_port_regs.v
// port 2 data register and port 0 set register behind an apb slave
//
// Operation
// [R1] 32-bit read/write port 2 data register at 0xffff0d40; upper bits reset zero.
// [R2] direction bits 30,29,28,25,24: zero makes pin input, one makes it output.
// [R3] pin 2.5 as output provides diagnostic write to high-voltage pins.
// [R4] pin 2.4 as input provides high-voltage readback chosen by config field.
// [R5] output bits 22,21,17,16 drive pins 2.6,2.5,2.1,2.0; none for 2.4.
// [R6] input bits 6,5,4,1,0 are read-only present pin levels; software writes zero.
// [R7] software writes zero to every reserved bit of both registers.
// [R8] 32-bit write-only port 0 set register at 0xffff0d24.
// [R9] ones in bits 20..16 of the set register drive port 0 pins 4..0 high.
// [R10] zeros in the set register leave the matching port 0 pin unchanged.
// [R11] a set write touches only pins whose bits are one.
// [R12] port 0 output levels for pins 0.4..0.0 are held; set ones force them high.
// [R13] an output value reaches its pin only while its direction bit selects output.
//
// Our own choice: register access over APB.
`timescale 1ns/1ns
`include "gpd_defines.vh"
module gpd_port_regs #(
    parameter P2_PINS = 5, // port 2 pins 2.0, 2.1, 2.4, 2.5, 2.6
    parameter P0_PINS = 5, // port 0 pins 0.0 .. 0.4
    parameter HV_PINS = 7, // high-voltage pins reachable by readback
    parameter HV_SELW = 3  // width of the readback select field
) (
    input  wire               clock,       // 125 MHz system clock
    input  wire               arst_n,      // async reset, active low
    // apb slave
    input  wire               psel,        // apb select
    input  wire               penable,     // apb access phase
    input  wire               pwrite,      // apb write
    input  wire [31:0]        paddr,       // apb byte address
    input  wire [31:0]        pwdata,      // apb write data
    input  wire [3:0]         pstrb,       // apb byte strobes
    output wire               pready,      // apb ready, zero wait states
    output reg  [31:0]        prdata,      // apb read data
    output reg                pslverr,     // apb error, unmapped address
    // port 2 pads
    input  wire [P2_PINS-1:0] p2PadIn,     // port 2 pad levels, asynchronous
    output wire [P2_PINS-1:0] p2PadOut,    // port 2 pad drive value
    output wire [P2_PINS-1:0] p2PadOe,     // port 2 pad drive enable
    // port 0 levels
    output wire [P0_PINS-1:0] p0Level,     // held port 0 output levels
    // high-voltage diagnostics
    output wire               hvDiagWrEn,  // diagnostic write path active
    output wire               hvDiagWrVal, // level sent on diagnostic write
    output wire               hvDiagRdEn,  // diagnostic readback path active
    input  wire [HV_SELW-1:0] hvCfgSel,    // readback select from the hv config
    input  wire [HV_PINS-1:0] hvLevelIn    // high-voltage pin levels, asynchronous
);

////////////////////////////////////////////////////////////////////////////////
// declarations

    reg  [P2_PINS-1:0] dir_reg;
    reg  [P2_PINS-1:0] dir_next;
    reg  [P2_PINS-1:0] out_reg;
    reg  [P2_PINS-1:0] out_next;
    reg  [P0_PINS-1:0] p0_reg;
    reg  [P0_PINS-1:0] p0_next;

    wire [P2_PINS-1:0] padSync;
    wire [HV_PINS-1:0] hvSync;
    wire [P2_PINS-1:0] wrDirBits;
    wire [P2_PINS-1:0] wrOutBits;
    wire [P2_PINS-1:0] inView;
    wire [31:0]        p2View;
    wire [P0_PINS-1:0] setBits;
    wire               setupRd;
    wire               setupErr;
    wire               hitP2;
    wire               wrP2;
    wire               wrP0Set;
    wire               hvSelValid;
    wire               hvPick;

////////////////////////////////////////////////////////////////////////////////
// pin numbering

    // maps the port-order index to the pin number inside port 2
    function integer pinNum;
        input integer idx;
        begin
            case (idx)
                0: pinNum = `GPD_P2_PIN0;
                1: pinNum = `GPD_P2_PIN1;
                2: pinNum = `GPD_P2_PIN2;
                3: pinNum = `GPD_P2_PIN3;
                4: pinNum = `GPD_P2_PIN4;
                default: pinNum = 0;
            endcase
        end
    endfunction

////////////////////////////////////////////////////////////////////////////////
// bus decode and synchronisers

    gpd_apb_decode u_decode (
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .setupRd  (setupRd),
        .setupErr (setupErr),
        .hitP2    (hitP2),
        .wrP2     (wrP2),
        .wrP0Set  (wrP0Set)
    );

    // pads come from outside the clock domain
    gpd_sync #(
        .WIDTH (P2_PINS)
    ) u_padSync (
        .clock   (clock),
        .arst_n  (arst_n),
        .asyncIn (p2PadIn),
        .syncOut (padSync)
    );

    gpd_sync #(
        .WIDTH (HV_PINS)
    ) u_hvSync (
        .clock   (clock),
        .arst_n  (arst_n),
        .asyncIn (hvLevelIn),
        .syncOut (hvSync)
    );

    // every transfer completes in its first access cycle
    assign pready = 1'b1;

////////////////////////////////////////////////////////////////////////////////
// per-pin field extraction, pad drive and readback view

    genvar k;
    generate
        for (k = 0; k < P2_PINS; k = k + 1) begin : g_pin
            // direction byte sits in lane 3, outputs in lane 2
            assign wrDirBits[k] = pwdata[`GPD_P2_DIR_BASE + pinNum(k)]; // [R2]
            if (k == `GPD_P2_NO_OUT_IDX) begin : g_noOut
                // no output bit: an output-configured 2.4 drives low
                assign wrOutBits[k] = 1'b0; // [R5]
            end else begin : g_out
                assign wrOutBits[k] = pwdata[`GPD_P2_OUT_BASE + pinNum(k)]; // [R5]
            end
            assign p2PadOe[k]  = dir_reg[k]; // [R2] [R13]
            // value is only driven while enabled; stored value is kept
            assign p2PadOut[k] = dir_reg[k] & out_reg[k]; // [R13] [R5]
            if (k == `GPD_P2_HVRD_IDX) begin : g_hvRd
                assign inView[k] = hvPick ? hvSync[hvCfgSel - 1'b1] : padSync[k]; // [R4]
            end else begin : g_in
                assign inView[k] = padSync[k]; // [R6]
            end
        end
    endgenerate

    // assemble the port 2 read image; reserved bits read as zero
    assign p2View = {1'b0,
                     dir_reg[4], dir_reg[3], dir_reg[2],
                     2'b00,
                     dir_reg[1], dir_reg[0],
                     1'b0,
                     out_reg[4], out_reg[3],
                     3'b000,
                     out_reg[1], out_reg[0],
                     9'h000,
                     inView[4], inView[3], inView[2],
                     2'b00,
                     inView[1], inView[0]}; // [R1] [R6]

////////////////////////////////////////////////////////////////////////////////
// high-voltage diagnostic paths

    // pin 2.5 as output carries the diagnostic write level
    assign hvDiagWrEn  = dir_reg[`GPD_P2_HVWR_IDX]; // [R3]
    assign hvDiagWrVal = dir_reg[`GPD_P2_HVWR_IDX] & out_reg[`GPD_P2_HVWR_IDX]; // [R3]
    // pin 2.4 as input carries readback of the selected hv pin
    assign hvDiagRdEn  = ~dir_reg[`GPD_P2_HVRD_IDX]; // [R4]
    // select zero means no hv pin; codes beyond the pin count fall back to the pad
    assign hvSelValid  = (hvCfgSel != {HV_SELW{1'b0}}) && (hvCfgSel <= HV_PINS);
    assign hvPick      = hvDiagRdEn & hvSelValid; // [R4]

////////////////////////////////////////////////////////////////////////////////
// port 0 set bits

    // reserved bits of the set word are ignored, not checked
    assign setBits = pwdata[`GPD_P0SET_MSB:`GPD_P0SET_LSB]; // [R9] [R7]

////////////////////////////////////////////////////////////////////////////////
// next-state logic

    always @* begin
        dir_next = dir_reg;
        out_next = out_reg;
        p0_next  = p0_reg;
        // lane strobes gate each field; input and reserved bits are dropped
        if (wrP2) begin
            if (pstrb[3]) begin
                dir_next = wrDirBits; // [R2] [R7]
            end
            if (pstrb[2]) begin
                out_next = wrOutBits; // [R5] [R6]
            end
        end
        if (wrP0Set && pstrb[2]) begin
            // or-in only: zeros leave pins, so no read-modify-write is needed
            p0_next = p0_reg | setBits; // [R9] [R10] [R11] [R12]
        end
    end

////////////////////////////////////////////////////////////////////////////////
// state registers

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dir_reg <= `GPD_DIR_RST; // [R1]
            out_reg <= `GPD_OUT_RST;
            p0_reg  <= `GPD_P0_RST;
        end else begin
            dir_reg <= dir_next;
            out_reg <= out_next;
            p0_reg  <= p0_next;
        end
    end

    assign p0Level = p0_reg; // [R12]

////////////////////////////////////////////////////////////////////////////////
// read data and error response

    // read data is captured in the setup cycle so it comes from a flop;
    // pin levels are therefore those of the setup edge, two flops behind the pads
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prdata  <= `GPD_RDATA_RST;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= setupErr;
            if (setupRd && hitP2) begin
                prdata <= p2View; // [R1] [R6]
            end else begin
                // the set register is write-only and reads as zero
                prdata <= `GPD_RDATA_RST; // [R8]
            end
        end
    end

endmodule // gpd_port_regs

//--- gpd_checker.sv
// concurrent checks on the port 2 data and port 0 set register block
`timescale 1ns/1ns
`include "gpd_defines.vh"
module gpd_checker #(
    parameter P2_PINS = 5, // port 2 pins
    parameter P0_PINS = 5  // port 0 pins
) (
    input wire               clock, arst_n, psel, penable, pwrite, // clock, reset, apb control
    input wire               pready, pslverr,                      // apb answer
    input wire [31:0]        paddr, pwdata, prdata,                // apb address and data
    input wire [3:0]         pstrb,                                // apb byte strobes
    input wire [P2_PINS-1:0] p2PadOe, p2PadOut,                    // port 2 pad drive
    input wire [P0_PINS-1:0] p0Level,                              // port 0 held levels
    input wire               hvDiagWrEn, hvDiagWrVal, hvDiagRdEn   // diagnostic paths
);
////////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge clock); endclocking
default disable iff (!arst_n);
wire wrP2   = psel && penable && pwrite && paddr == `GPD_P2_ADDR;
wire wrSet  = psel && penable && pwrite && paddr == `GPD_P0SET_ADDR && pstrb[2];
wire mapped = paddr == `GPD_P2_ADDR || paddr == `GPD_P0SET_ADDR;
sequence seqSetup; psel && !penable; endsequence
sequence seqAccess; psel && penable; endsequence
////////////////////////////////////////////////////////////////////////////////
AST_READY: assert property (pready)
    else $error("pready low");
AST_DIR: assert property (wrP2 && pstrb[3] |=>
    p2PadOe == {$past(pwdata[30:28]), $past(pwdata[25:24])}) else $error("direction not taken");
AST_OUT: assert property (wrP2 && pstrb == 4'hf |=> p2PadOut ==
    ({$past(pwdata[30:28]), $past(pwdata[25:24])} & {$past(pwdata[22:21]), 1'b0,
    $past(pwdata[17:16])})) else $error("pad drive wrong");
AST_HVWR: assert property (hvDiagWrEn == p2PadOe[3] && hvDiagWrVal == p2PadOut[3])
    else $error("diagnostic write path wrong");
AST_HVRD: assert property (hvDiagRdEn == !p2PadOe[2])
    else $error("diagnostic readback path wrong");
AST_SET: assert property (wrSet |=> p0Level == ($past(p0Level) | $past(pwdata[20:16])))
    else $error("set write wrong");
AST_KEEP: assert property (!wrSet |=> $stable(p0Level))
    else $error("port 0 level moved");
AST_ERR: assert property (seqSetup ##1 seqAccess |-> pslverr == !$past(mapped))
    else $error("error flag wrong");
AST_WO: assert property (psel && !penable && !pwrite && paddr == `GPD_P0SET_ADDR |=>
    prdata == 32'h00000000) else $error("set register read not zero");
AST_VIEW: assert property (psel && !penable && !pwrite && paddr == `GPD_P2_ADDR |=>
    (prdata & 32'h8c9cff8c) == 32'h0 && {prdata[30:28], prdata[25:24]} == p2PadOe)
    else $error("read view wrong");
endmodule // gpd_checker

bind gpd_port_regs gpd_checker #(.P2_PINS(P2_PINS), .P0_PINS(P0_PINS)) u_gpd_checker (
    .clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pstrb(pstrb), .p2PadOe(p2PadOe), .p2PadOut(p2PadOut), .p0Level(p0Level),
    .hvDiagWrEn(hvDiagWrEn), .hvDiagWrVal(hvDiagWrVal), .hvDiagRdEn(hvDiagRdEn));

//--- gpd_pad_model.sv
// outside circuitry on the port 2 pads
`timescale 1ns/1ns
module gpd_pad_model (
    input  wire [4:0] padOe,    // device drive enable
    input  wire [4:0] padOut,   // device drive value
    input  wire [4:0] extLevel, // level of the outside circuit when not driven
    output wire [4:0] padIn     // resolved pad level
);
// a released pad falls back to the outside circuit, never to the last driven value
assign padIn = (padOe & padOut) | (~padOe & extLevel);
endmodule // gpd_pad_model

//--- gpio_port2_data_port0_set_test.sv
// self-checking bench for the port 2 data and port 0 set registers
`timescale 1ns/1ns
`include "gpd_defines.vh"
module gpio_port2_data_port0_set_test;
typedef struct packed {logic [31:0] a, w; logic [3:0] s; logic [4:0] d, o, p; logic e;} gpd_row_t;
logic clock = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, errv;
logic [31:0] paddr = 0, pwdata = 0, prdata, rdv;
logic [3:0]  pstrb = 0;
logic [4:0]  p2PadIn, p2PadOut, p2PadOe, p0Level, lv, ext = 5'h15;
logic        hvDiagWrEn, hvDiagWrVal, hvDiagRdEn;
logic [2:0]  hvCfgSel = 0;
logic [6:0]  hvLevelIn = 7'h2a;
int          failures = 0, samples_checked = 0, i;
localparam [31:0] P2 = `GPD_P2_ADDR, PS = `GPD_P0SET_ADDR;
// reserved and input bits of both registers are always written as zero
gpd_row_t rows [10] = '{'{P2, 32'h00000000, 4'hf, 5'h00, 5'h00, 5'h00, 1'b0},
    '{P2, 32'h73630000, 4'hf, 5'h1f, 5'h1b, 5'h00, 1'b0},
    '{P2, 32'h03000000, 4'h8, 5'h03, 5'h1b, 5'h00, 1'b0},
    '{P2, 32'h00600000, 4'h4, 5'h03, 5'h18, 5'h00, 1'b0},
    '{P2, 32'h70000000, 4'hf, 5'h1c, 5'h00, 5'h00, 1'b0},
    '{PS, 32'h00110000, 4'hf, 5'h1c, 5'h00, 5'h11, 1'b0},
    '{PS, 32'h000e0000, 4'h3, 5'h1c, 5'h00, 5'h11, 1'b0},
    '{PS, 32'h00000000, 4'hf, 5'h1c, 5'h00, 5'h11, 1'b0},
    '{PS, 32'h000a0000, 4'hf, 5'h1c, 5'h00, 5'h1b, 1'b0},
    '{32'hffff0d44, 32'hffffffff, 4'hf, 5'h1c, 5'h00, 5'h1b, 1'b1}};
////////////////////////////////////////////////////////////////////////////////
always #4 clock = ~clock;
gpd_port_regs u_gpd_port_regs (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .p2PadIn(p2PadIn), .p2PadOut(p2PadOut),
    .p2PadOe(p2PadOe), .p0Level(p0Level), .hvDiagWrEn(hvDiagWrEn), .hvDiagWrVal(hvDiagWrVal),
    .hvDiagRdEn(hvDiagRdEn), .hvCfgSel(hvCfgSel), .hvLevelIn(hvLevelIn));
gpd_pad_model u_gpd_pad_model (.padOe(p2PadOe), .padOut(p2PadOut), .extLevel(ext),
    .padIn(p2PadIn));
////////////////////////////////////////////////////////////////////////////////
function automatic [31:0] p2View(input [4:0] d, input [4:0] o, input [4:0] lv);
    p2View = {1'b0, d[4:2], 2'b0, d[1:0], 1'b0, o[4:3], 3'b0, o[1:0], 9'b0, lv[4:2], 2'b0, lv[1:0]};
endfunction
task automatic check(input [31:0] seen, input [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
        failures++;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
endtask
task automatic apb(input [31:0] a, input w, input [31:0] d, input [3:0] s);
    @(posedge clock);
    psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d; pstrb <= s;
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 0; penable <= 0;
endtask
task results;
    $display("checked %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    #200000;
    failures++;
    results;
end
initial begin
    repeat (19) @(posedge clock);
    check(p2PadOe, 5'h00);
    check(p0Level, 5'h00);
    check(hvDiagRdEn, 1'b1);
    @(posedge clock);
    arst_n <= 1;
    for (i = 0; i < 10; i++) begin
        apb(rows[i].a, 1, rows[i].w, rows[i].s);
        check(errv, rows[i].e);
        repeat (3) @(posedge clock);
        check(p2PadOe, rows[i].d);
        check(p2PadOut, rows[i].d & rows[i].o);
        check(p0Level, rows[i].p);
        check(hvDiagWrEn, rows[i].d[3]);
        check(hvDiagWrVal, rows[i].d[3] & rows[i].o[3]);
        check(hvDiagRdEn, !rows[i].d[2]);
        lv = (rows[i].d & rows[i].o) | (~rows[i].d & ext);
        apb(P2, 0, 0, 0);
        check(rdv, p2View(rows[i].d, rows[i].o, lv));
    end
    // write-only register reads zero, unmapped read flags an error
    apb(PS, 0, 0, 0);
    check(rdv, 0);
    check(errv, 0);
    apb(32'hffff0d20, 0, 0, 0);
    check(errv, 1);
    check(rdv, 0);
    apb(P2, 1, 32'h0, 4'hf);
    ext <= 5'h0a;
    for (i = 0; i < 8; i++) begin
        hvCfgSel <= i[2:0];
        repeat (3) @(posedge clock);
        apb(P2, 0, 0, 0);
        check(rdv[4], i == 0 ? ext[2] : hvLevelIn[i-1]);
        check({rdv[6:5], rdv[1:0]}, {ext[4:3], ext[1:0]});
    end
    // 2.4 as output closes the readback path even with a select that reads high
    hvCfgSel <= 3'h2;
    apb(P2, 1, 32'h10000000, 4'hf);
    repeat (3) @(posedge clock);
    apb(P2, 0, 0, 0);
    check(rdv[4], 1'b0);
    check(rdv[28], 1'b1);
    check(hvDiagRdEn, 1'b0);
    arst_n <= 0;
    @(posedge clock);
    check(p0Level, 5'h00);
    check(p2PadOe, 5'h00);
    check(hvDiagRdEn, 1'b1);
    @(posedge clock);
    arst_n <= 1;
    @(posedge clock);
    check(p2PadOe, 5'h00);
    check(prdata, 32'h00000000);
    // a set right after reset shows the held levels were cleared
    apb(PS, 1, 32'h00040000, 4'hf);
    @(posedge clock);
    check(p0Level, 5'h04);
    results;
end
endmodule // gpio_port2_data_port0_set_test
